// [verilog/mpd_pkg.sv]
// shared constants for the move/push opcode decoder
package mpd_pkg;
   // opcode patterns
   localparam logic [3:0] MPD_OP_IMM_REG = 4'hB;      // 1011 w reg
   localparam logic [6:0] MPD_OP_LOAD_ACC = 7'h50;    // 1010000 w
   localparam logic [6:0] MPD_OP_STORE_ACC = 7'h51;   // 1010001 w
   localparam logic [7:0] MPD_OP_SEG_LOAD = 8'h8E;
   localparam logic [7:0] MPD_OP_SEG_STORE = 8'h8C;
   localparam logic [7:0] MPD_OP_ESCAPE = 8'h0F;
   localparam logic [6:0] MPD_OP2_SIGN_EXT = 7'h5F;   // 1011111 w, second byte after escape
   localparam logic [6:0] MPD_OP2_ZERO_EXT = 7'h5B;   // 1011011 w, second byte after escape
   localparam logic [7:0] MPD_OP_GROUP_FF = 8'hFF;
   localparam logic [2:0] MPD_REG_PUSH = 3'h6;
   // field positions
   localparam int MPD_W_SHORT_POS = 3;  // width bit in short immediate form
   localparam int MPD_W_POS = 0;        // width bit elsewhere
   localparam int MPD_MODE_HI = 7;
   localparam int MPD_MODE_LO = 6;
   localparam int MPD_REG_HI = 5;
   localparam int MPD_REG_LO = 3;
   localparam logic [1:0] MPD_MODE_REGISTER = 2'h3;
   // clock counts: first column, second column, register/memory operand
   localparam logic [4:0] MPD_CLK_IMM = 5'h02;
   localparam logic [4:0] MPD_CLK_LOAD_ACC = 5'h04;
   localparam logic [4:0] MPD_CLK_STORE_ACC = 5'h02;
   localparam logic [4:0] MPD_CLK_SEGL_C1_REG = 5'h02;
   localparam logic [4:0] MPD_CLK_SEGL_C1_MEM = 5'h05;
   localparam logic [4:0] MPD_CLK_SEGL_C2_REG = 5'h16;  // 22
   localparam logic [4:0] MPD_CLK_SEGL_C2_MEM = 5'h17;  // 23
   localparam logic [4:0] MPD_CLK_SEGS = 5'h02;
   localparam logic [4:0] MPD_CLK_EXT_REG = 5'h03;
   localparam logic [4:0] MPD_CLK_EXT_MEM = 5'h06;
   localparam logic [4:0] MPD_CLK_PUSH_C1_REG = 5'h05;
   localparam logic [4:0] MPD_CLK_PUSH_C1_MEM = 5'h07;
   localparam logic [4:0] MPD_CLK_PUSH_C2_REG = 5'h07;
   localparam logic [4:0] MPD_CLK_PUSH_C2_MEM = 5'h09;
   // reset values
   localparam logic [4:0] MPD_CLK_RESET = 5'h00;
   localparam logic [31:0] MPD_DATA_RESET = 32'h0000_0000;

   typedef enum logic [3:0] {
      MPD_K_NONE,
      MPD_K_IMM_REG,
      MPD_K_LOAD_ACC,
      MPD_K_STORE_ACC,
      MPD_K_SEG_LOAD,
      MPD_K_SEG_STORE,
      MPD_K_SIGN_EXT,
      MPD_K_ZERO_EXT,
      MPD_K_PUSH
   } mpd_kind_t;
endpackage

// [verilog/mpd_extend.sv]
// operand extension unit: byte or word source widened to full width
module mpd_extend
   import mpd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // request
   input wire logic start,
   input wire logic sign_mode,
   input wire logic full_width,
   input wire logic [15:0] src,
   // result
   output logic [31:0] result
);
   logic [31:0] next_result;

   // fill bit is the source msb for signed moves, zero otherwise
   always_comb begin
      next_result = result;
      if (start) begin
         if (full_width) begin
            next_result = {{16{sign_mode & src[15]}}, src};
         end else begin
            next_result = {{24{sign_mode & src[7]}}, src[7:0]};
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= MPD_DATA_RESET;
      end else begin
         result <= next_result;
      end
   end

   property p_sign_fill;
      @(posedge clk) disable iff (!arst_n)
         (start && sign_mode && !full_width && src[7]) |=> (result[31:8] == 24'hFFFFFF);
   endproperty
   a_sign_fill: assert property (p_sign_fill) else $error("sign fill wrong");
   property p_zero_fill;
      @(posedge clk) disable iff (!arst_n)
         (start && !sign_mode && full_width) |=> (result[31:16] == 16'h0000);
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("zero fill wrong");
endmodule

// [verilog/mpd_decoder.sv]
// move and push opcode decoder with clock-count lookup
module mpd_decoder
   import mpd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // instruction bytes from fetch
   input wire logic op_valid,
   input wire logic [7:0] op_byte0,
   input wire logic [7:0] op_byte1,
   input wire logic [7:0] op_byte2,
   // source operand for extension moves
   input wire logic [15:0] ext_src,
   // decode results
   output logic dec_valid,
   output mpd_kind_t dec_kind,
   output logic dec_full_width,
   output logic [2:0] dec_reg,
   output logic [2:0] seg_select_field,
   output logic dec_mem_operand,
   output logic [4:0] dec_clocks_c1,
   output logic [4:0] dec_clocks_c2,
   // extended operand, one cycle after dec_valid for extension moves
   output logic [31:0] ext_result
);
   // operand is memory unless mode field says register
   function automatic logic is_mem(input logic [7:0] modrm);
      is_mem = (modrm[MPD_MODE_HI:MPD_MODE_LO] != MPD_MODE_REGISTER);
   endfunction

   // pick clock count by operand kind
   function automatic logic [4:0] pick(input logic mem, input logic [4:0] r, input logic [4:0] m);
      pick = mem ? m : r;
   endfunction

   logic next_valid;
   mpd_kind_t next_kind;
   logic next_full_width;
   logic [2:0] next_reg;
   logic [2:0] next_seg;
   logic next_mem;
   logic [4:0] next_c1;
   logic [4:0] next_c2;
   logic ext_start;
   logic [7:0] modrm;

   // decode: one byte pattern at a time, escape form checked first
   always_comb begin
      next_valid = 1'b0;
      next_kind = MPD_K_NONE;
      next_full_width = 1'b0;
      next_reg = 3'h0;
      next_seg = 3'h0;
      next_mem = 1'b0;
      next_c1 = MPD_CLK_RESET;
      next_c2 = MPD_CLK_RESET;
      modrm = op_byte1;
      if (op_valid) begin
         if (op_byte0 == MPD_OP_ESCAPE) begin
            modrm = op_byte2;
            // seven-bit pattern with the width bit last; bytes next to it are other opcodes
            if (op_byte1[7:1] == MPD_OP2_SIGN_EXT) begin
               next_kind = MPD_K_SIGN_EXT;
            end else if (op_byte1[7:1] == MPD_OP2_ZERO_EXT) begin
               next_kind = MPD_K_ZERO_EXT;
            end
            if (next_kind != MPD_K_NONE) begin
               next_full_width = op_byte1[MPD_W_POS];
               next_reg = modrm[MPD_REG_HI:MPD_REG_LO];
               next_mem = is_mem(modrm);
               next_c1 = pick(next_mem, MPD_CLK_EXT_REG, MPD_CLK_EXT_MEM);
               next_c2 = next_c1;
            end
         end else if (op_byte0[7:4] == MPD_OP_IMM_REG) begin
            next_kind = MPD_K_IMM_REG;
            next_full_width = op_byte0[MPD_W_SHORT_POS];
            next_reg = op_byte0[2:0];
            next_c1 = MPD_CLK_IMM;
            next_c2 = MPD_CLK_IMM;
         end else if (op_byte0[7:1] == MPD_OP_LOAD_ACC) begin
            next_kind = MPD_K_LOAD_ACC;
            next_full_width = op_byte0[MPD_W_POS];
            next_mem = 1'b1;
            next_c1 = MPD_CLK_LOAD_ACC;
            next_c2 = MPD_CLK_LOAD_ACC;
         end else if (op_byte0[7:1] == MPD_OP_STORE_ACC) begin
            next_kind = MPD_K_STORE_ACC;
            next_full_width = op_byte0[MPD_W_POS];
            next_mem = 1'b1;
            next_c1 = MPD_CLK_STORE_ACC;
            next_c2 = MPD_CLK_STORE_ACC;
         end else if (op_byte0 == MPD_OP_SEG_LOAD) begin
            next_kind = MPD_K_SEG_LOAD;
            next_full_width = 1'b1;
            next_seg = modrm[MPD_REG_HI:MPD_REG_LO];
            next_mem = is_mem(modrm);
            next_c1 = pick(next_mem, MPD_CLK_SEGL_C1_REG, MPD_CLK_SEGL_C1_MEM);
            next_c2 = pick(next_mem, MPD_CLK_SEGL_C2_REG, MPD_CLK_SEGL_C2_MEM);
         end else if (op_byte0 == MPD_OP_SEG_STORE) begin
            next_kind = MPD_K_SEG_STORE;
            next_full_width = 1'b1;
            next_seg = modrm[MPD_REG_HI:MPD_REG_LO];
            next_mem = is_mem(modrm);
            next_c1 = MPD_CLK_SEGS;
            next_c2 = MPD_CLK_SEGS;
         end else if (op_byte0 == MPD_OP_GROUP_FF &&
                      modrm[MPD_REG_HI:MPD_REG_LO] == MPD_REG_PUSH) begin
            next_kind = MPD_K_PUSH;
            next_full_width = 1'b1;
            next_mem = is_mem(modrm);
            next_c1 = pick(next_mem, MPD_CLK_PUSH_C1_REG, MPD_CLK_PUSH_C1_MEM);
            next_c2 = pick(next_mem, MPD_CLK_PUSH_C2_REG, MPD_CLK_PUSH_C2_MEM);
         end
         next_valid = (next_kind != MPD_K_NONE);
      end
   end

   // registered outputs so downstream sees stable data for a whole cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dec_valid <= 1'b0;
         dec_kind <= MPD_K_NONE;
         dec_full_width <= 1'b0;
         dec_reg <= 3'h0;
         seg_select_field <= 3'h0;
         dec_mem_operand <= 1'b0;
         dec_clocks_c1 <= MPD_CLK_RESET;
         dec_clocks_c2 <= MPD_CLK_RESET;
      end else begin
         dec_valid <= next_valid;
         dec_kind <= next_kind;
         dec_full_width <= next_full_width;
         dec_reg <= next_reg;
         seg_select_field <= next_seg;
         dec_mem_operand <= next_mem;
         dec_clocks_c1 <= next_c1;
         dec_clocks_c2 <= next_c2;
      end
   end

   // extension runs off the registered decode, hence one cycle later
   assign ext_start = dec_valid && (dec_kind == MPD_K_SIGN_EXT || dec_kind == MPD_K_ZERO_EXT);

   mpd_extend u_extend (
      .clk(clk),
      .arst_n(arst_n),
      .start(ext_start),
      .sign_mode(dec_kind == MPD_K_SIGN_EXT),
      .full_width(dec_full_width),
      .src(ext_src),
      .result(ext_result)
   );

   // decode checks use literal figures, so a wrong package constant still shows up
   property p_imm;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0[7:4] == 4'hB) |=>
            (dec_kind == MPD_K_IMM_REG && dec_clocks_c1 == 5'h02 && dec_clocks_c2 == 5'h02);
   endproperty
   a_imm: assert property (p_imm) else $error("short immediate decode wrong");
   property p_load_acc;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0[7:1] == 7'h50) |=> (dec_kind == MPD_K_LOAD_ACC && dec_clocks_c1 == 5'h04);
   endproperty
   a_load_acc: assert property (p_load_acc) else $error("accumulator load decode wrong");
   property p_store_acc;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0[7:1] == 7'h51) |=> (dec_kind == MPD_K_STORE_ACC && dec_clocks_c2 == 5'h02);
   endproperty
   a_store_acc: assert property (p_store_acc) else $error("accumulator store decode wrong");
   property p_seg_load;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'h8E && op_byte1[7:6] != 2'h3) |=>
            (dec_clocks_c1 == 5'h05 && dec_clocks_c2 == 5'h17);
   endproperty
   a_seg_load: assert property (p_seg_load) else $error("segment load timing wrong");
   property p_seg_store;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'h8C) |=>
            (dec_kind == MPD_K_SEG_STORE && seg_select_field == $past(op_byte1[5:3]));
   endproperty
   a_seg_store: assert property (p_seg_store) else $error("segment store decode wrong");
   property p_sign_ext;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'h0F && op_byte1[7:1] == 7'h5F && op_byte2[7:6] == 2'h3) |=>
            (dec_kind == MPD_K_SIGN_EXT && dec_clocks_c1 == 5'h03);
   endproperty
   a_sign_ext: assert property (p_sign_ext) else $error("sign extend decode wrong");
   property p_zero_ext;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'h0F && op_byte1[7:1] == 7'h5B && op_byte2[7:6] != 2'h3) |=>
            (dec_kind == MPD_K_ZERO_EXT && dec_clocks_c2 == 5'h06);
   endproperty
   a_zero_ext: assert property (p_zero_ext) else $error("zero extend decode wrong");
   property p_push;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'hFF && op_byte1[5:3] == 3'h6 && op_byte1[7:6] == 2'h3) |=>
            (dec_kind == MPD_K_PUSH && dec_clocks_c1 == 5'h05 && dec_clocks_c2 == 5'h07);
   endproperty
   a_push: assert property (p_push) else $error("push decode wrong");
   property p_width;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0[7:1] == 7'h50) |=> (dec_full_width == $past(op_byte0[0]));
   endproperty
   a_width: assert property (p_width) else $error("width bit wrong");
   // group 0xFF only pushes when the reg field says so
   property p_push_refused;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'hFF && op_byte1[5:3] != 3'h6) |=> (!dec_valid && dec_kind == MPD_K_NONE);
   endproperty
   a_push_refused: assert property (p_push_refused) else $error("refused push form decoded");
   // extension moves carry the width bit in bit 0 of the second byte
   property p_ext_width;
      @(posedge clk) disable iff (!arst_n)
         (op_valid && op_byte0 == 8'h0F && (op_byte1[7:1] == 7'h5F || op_byte1[7:1] == 7'h5B)) |=>
            (dec_full_width == $past(op_byte1[0]));
   endproperty
   a_ext_width: assert property (p_ext_width) else $error("extension width bit wrong");
endmodule

// [verif/tb_move_push_opcode_decode.sv]
// self-checking bench for the move and push opcode decoder
module tb_move_push_opcode_decode import mpd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // expected decode outcome for one taken cycle
   typedef struct packed {
      logic v;
      mpd_kind_t k;
      logic fw;
      logic [2:0] r;
      logic [2:0] s;
      logic m;
      logic [4:0] c1;
      logic [4:0] c2;
   } mpd_note_t;

   logic clk, arst_n, op_valid, dec_valid, dec_full_width, dec_mem_operand;
   logic [7:0] op_byte0, op_byte1, op_byte2;
   logic [15:0] ext_src;
   mpd_kind_t dec_kind;
   logic [2:0] dec_reg, seg_select_field;
   logic [4:0] dec_clocks_c1, dec_clocks_c2;
   logic [31:0] ext_result, exp_ext;
   logic prev_ext, prev_sign, prev_w;
   mpd_note_t dec_q[$];
   logic [31:0] ext_q[$];
   logic [23:0] dir [16];
   int n_mismatch, checked;

   mpd_decoder uut (
      .clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_byte0(op_byte0), .op_byte1(op_byte1),
      .op_byte2(op_byte2), .ext_src(ext_src), .dec_valid(dec_valid), .dec_kind(dec_kind),
      .dec_full_width(dec_full_width), .dec_reg(dec_reg), .seg_select_field(seg_select_field),
      .dec_mem_operand(dec_mem_operand), .dec_clocks_c1(dec_clocks_c1), .dec_clocks_c2(dec_clocks_c2),
      .ext_result(ext_result));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // reference decode, worked out independently of the design
   function automatic mpd_note_t predict(logic v, logic [7:0] b0, logic [7:0] b1, logic [7:0] b2);
      mpd_note_t n;
      n = '0;
      n.k = MPD_K_NONE;
      if (v) begin
         if (b0 == 8'h0F) begin
            if (b1[7:1] == 7'h5F || b1[7:1] == 7'h5B) begin
               n.m = b2[7:6] != 2'h3;
               n.k = b1[3] ? MPD_K_SIGN_EXT : MPD_K_ZERO_EXT;
               n.fw = b1[0];
               n.r = b2[5:3];
               n.c1 = n.m ? 5'h06 : 5'h03;
               n.c2 = n.c1;
            end
         end else if (b0[7:4] == 4'hB) begin
            n.k = MPD_K_IMM_REG;
            n.fw = b0[3];
            n.r = b0[2:0];
            n.c1 = 5'h02;
            n.c2 = 5'h02;
         end else if (b0[7:2] == 6'h28) begin
            n.k = b0[1] ? MPD_K_STORE_ACC : MPD_K_LOAD_ACC;
            n.fw = b0[0];
            n.m = 1'b1;
            n.c1 = b0[1] ? 5'h02 : 5'h04;
            n.c2 = n.c1;
         end else if (b0 == 8'h8E || b0 == 8'h8C) begin
            n.m = b1[7:6] != 2'h3;
            n.k = b0[1] ? MPD_K_SEG_LOAD : MPD_K_SEG_STORE;
            n.fw = 1'b1;
            n.s = b1[5:3];
            n.c1 = (b0[1] && n.m) ? 5'h05 : 5'h02;
            n.c2 = b0[1] ? (n.m ? 5'h17 : 5'h16) : 5'h02;
         end else if (b0 == 8'hFF && b1[5:3] == 3'h6) begin
            n.m = b1[7:6] != 2'h3;
            n.k = MPD_K_PUSH;
            n.fw = 1'b1;
            n.c1 = n.m ? 5'h07 : 5'h05;
            n.c2 = n.m ? 5'h09 : 5'h07;
         end
      end
      n.v = n.k != MPD_K_NONE;
      return n;
   endfunction

   task automatic compare_dec(input mpd_note_t e);
      checked++;
      if (dec_valid !== e.v || dec_kind !== e.k || dec_clocks_c1 !== e.c1 || dec_clocks_c2 !== e.c2 ||
          (e.v && {dec_full_width, dec_reg, seg_select_field, dec_mem_operand} !== {e.fw, e.r, e.s, e.m})) begin
         n_mismatch++;
         $display("unexpected at %0t: decode kind %0d, wanted %0d", $time, dec_kind, e.k);
      end
   endtask

   task automatic compare_ext(input logic [31:0] e);
      checked++;
      if (ext_result !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: extended operand %h, wanted %h", $time, ext_result, e);
      end
   endtask

   // one cycle of fetch; ext_src serves the previous cycle's extension move
   task automatic drive(input logic v, input logic [7:0] b0, b1, b2, input logic [15:0] src);
      mpd_note_t n;
      @(negedge clk);
      op_valid = v;
      op_byte0 = b0;
      op_byte1 = b1;
      op_byte2 = b2;
      ext_src = src;
      n = predict(v, b0, b1, b2);
      dec_q.push_back(n);
      if (prev_ext) begin
         exp_ext = prev_w ? {(prev_sign ? {16{src[15]}} : 16'h0000), src} :
                            {(prev_sign ? {24{src[7]}} : 24'h000000), src[7:0]};
      end
      ext_q.push_back(exp_ext);
      prev_ext = n.k == MPD_K_SIGN_EXT || n.k == MPD_K_ZERO_EXT;
      prev_sign = n.k == MPD_K_SIGN_EXT;
      prev_w = n.fw;
   endtask

   task automatic drive_random;
      logic [31:0] r;
      logic [7:0] b0;
      r = $urandom;
      case (r[2:0])
         3'h0: b0 = {4'hB, r[7:4]};
         3'h1: b0 = {7'h50, r[8]};
         3'h2: b0 = {7'h51, r[8]};
         3'h3: b0 = 8'h8E;
         3'h4: b0 = 8'h8C;
         3'h5: b0 = 8'h0F;
         3'h6: b0 = 8'hFF;
         default: b0 = r[23:16];
      endcase
      drive(r[15:13] != 3'h0, b0, (b0 == 8'h0F && r[10]) ? {4'hB, r[11], 2'h3, r[12]} : 8'($urandom),
            8'($urandom), 16'($urandom));
   endtask

   // watcher: each taken cycle leaves one note per result kind
   initial begin
      forever begin
         @(posedge clk);
         #1;
         if (dec_q.size() > 0) compare_dec(dec_q.pop_front());
         if (ext_q.size() > 0) compare_ext(ext_q.pop_front());
      end
   end

   task automatic print_verdict;
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, well beyond the roughly 650 cycles of stimulus
   initial begin
      #50000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h84B6));
      {arst_n, op_valid, op_byte0, op_byte1, op_byte2, ext_src} = '0;
      {exp_ext, prev_ext, prev_sign, prev_w} = '0;
      n_mismatch = 0;
      checked = 0;
      dir = '{24'hB50000, 24'hBF0000, 24'hA00000, 24'hA30000, 24'h8EC800, 24'h8E1000, 24'h8CD800, 24'h8C0000,
              24'h0FB6C0, 24'h0FB705, 24'h0FBE00, 24'hFFF000, 24'hFF3600, 24'hFFC000, 24'h0F0000, 24'h620000};
      repeat (5) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      drive(1'b1, 8'h0F, 8'hBF, 8'hC8, 16'h0000);
      drive(1'b0, 8'h00, 8'h00, 8'h00, 16'h8000);
      // every form back to back, refusals among them
      foreach (dir[i]) drive(1'b1, dir[i][23:16], dir[i][15:8], dir[i][7:0], 16'($urandom));
      repeat (600) drive_random();
      drive(1'b0, 8'h00, 8'h00, 8'h00, 16'hFFFF);
      @(posedge clk);
      #2;
      // reset in mid-run with a legal opcode still offered
      @(negedge clk);
      arst_n = 1'b0;
      op_valid = 1'b1;
      op_byte0 = 8'hB3;
      @(posedge clk);
      #1;
      compare_dec(predict(1'b0, 8'h00, 8'h00, 8'h00));
      compare_ext(32'h0000_0000);
      @(negedge clk);
      arst_n = 1'b1;
      {exp_ext, prev_ext} = '0;
      // the opcode left up is taken at the first edge after release
      dec_q.push_back(predict(1'b1, op_byte0, op_byte1, op_byte2));
      ext_q.push_back(32'h0000_0000);
      repeat (20) drive_random();
      drive(1'b0, 8'h00, 8'h00, 8'h00, 16'h0000);
      repeat (2) @(posedge clk);
      #2;
      // a note never consumed means a result never appeared
      if (dec_q.size() != 0 || ext_q.size() != 0) n_mismatch++;
      print_verdict();
   end
endmodule
